// file: logic/timer_channel.sv
// One timer channel: modes 0..3 counting, compare and overflow flags.
// Assumes prescaler tick is a one-cycle pulse synchronous to mclk.
//
// Notes on behaviour
// - four-bit field selects operating mode
// - mode 0: pin GPIO, compare and overflow irqs
// - enable clears, first tick loads, then increments
// - modes 0-2 tick from mclk/2 or prescaler
// - match sets compare flag, optional interrupt
// - reload on match when reload bit set
// - overflow sets flag, optional interrupt
// - count value readable anytime, undisturbed
// - modes 1,2 pin output, starts at invert
// - mode 1 match inverts pin one tick
// - mode 2 match toggles pin, sets flag
// - mode 3 pin input, edges or prescaler
// - external clock synchronised, below quarter rate
// - invert bit picks counted pin edge
// - load value and counter 24 bits
// - overflow flag cleared by one or service
// - compare flag cleared by one or service
`timescale 1ns/100ps
module timer_channel #(
	parameter int CW = timer_pkg::COUNT_WIDTH
) (
	// Clock and reset
	input  wire logic          mclk,
	input  wire logic          rst,
	// Control fields
	input  wire logic [3:0]    mode_select_field,
	input  wire logic          channel_enable_bit,
	input  wire logic          reload_on_match,
	input  wire logic          polarity_invert,
	input  wire logic          prescaler_select,
	input  wire logic          prescaler_tick,
	input  wire logic          compare_irq_enable,
	input  wire logic          overflow_irq_enable,
	// Values
	input  wire logic [CW-1:0] load_value_reg,
	input  wire logic [CW-1:0] compare_value_reg,
	// Flag clears
	input  wire logic          compare_flag_write_one,
	input  wire logic          compare_irq_serviced,
	input  wire logic          overflow_flag_write_one,
	input  wire logic          overflow_irq_serviced,
	// GPIO pin value before polarity_invert, when pin is general-purpose output
	input  wire logic          gpio_out,
	input  wire logic          gpio_drive,
	// Timer pin
	input  wire logic          timer_pin_in,
	output logic               timer_pin_out,
	output logic               timer_pin_oe_n,
	// Status
	output logic [CW-1:0]      count_value_reg,
	output logic               compare_flag,
	output logic               overflow_flag,
	output logic               compare_irq,
	output logic               overflow_irq
);
	// ------------------------------------------------------------
	// Mode decode
	// ------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_RUN} state_e;
	state_e state;
	state_e next_state;

	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          div_phase;
	logic          pin_rise;
	logic          pin_fall;
	logic          pulse_active;
	logic          pin_drive;
	logic          next_pin_drive;

	wire mode_gpio   = mode_select_field == timer_pkg::MODE_GPIO;
	wire mode_pulse  = mode_select_field == timer_pkg::MODE_PULSE;
	wire mode_toggle = mode_select_field == timer_pkg::MODE_TOGGLE;
	wire mode_event  = mode_select_field == timer_pkg::MODE_EVENT;
	// Only modes 0..3 run here; others leave the channel idle
	wire mode_count  = mode_gpio | mode_pulse | mode_toggle | mode_event;
	wire pin_is_out  = mode_pulse | mode_toggle;

	// ------------------------------------------------------------
	// Timer clock sources
	// ------------------------------------------------------------
	pin_edge_sync u_sync (
		.mclk   (mclk),
		.rst    (rst),
		.pin_in (timer_pin_in),
		.level  (),
		.rise   (pin_rise),
		.fall   (pin_fall)
	);

	// Divider runs free so CLK/2 needs no extra enable path
	always_ff @(posedge mclk) begin
		if (rst) begin
			div_phase <= 1'b0;
		end else begin
			div_phase <= ~div_phase;
		end
	end

	wire tick_internal = prescaler_select ? prescaler_tick : div_phase;
	wire pin_edge      = polarity_invert ? pin_fall : pin_rise;
	wire tick_event    = prescaler_select ? prescaler_tick : pin_edge;
	wire tick          = mode_event ? tick_event : tick_internal;

	// ------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------
	wire running   = channel_enable_bit & mode_count;
	wire count_tick = running & tick;
	wire match     = state == ST_RUN && count == compare_value_reg;
	wire overflow  = state == ST_RUN && count == {CW{1'b1}};

	always_comb begin
		next_state = state;
		next_count = count;
		case (state)
			ST_IDLE: begin
				// Enable clears the count in every mode, counting or not
				if (channel_enable_bit) begin
					next_count = timer_pkg::COUNT_RESET;
				end
				if (running) begin
					next_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (!running) begin
					next_state = ST_IDLE;
				end else if (tick) begin
					next_state = ST_RUN;
					next_count = load_value_reg;
				end
			end
			ST_RUN: begin
				if (!running) begin
					next_state = ST_IDLE;
				end else if (tick) begin
					// reload at the tick that sees the match
					if (match && reload_on_match) begin
						next_count = load_value_reg;
					end else begin
						next_count = count + 1'b1;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state <= ST_IDLE;
			count <= timer_pkg::COUNT_RESET;
		end else begin
			state <= next_state;
			count <= next_count;
		end
	end

	// ------------------------------------------------------------
	// Flags; a set in the clearing cycle wins
	// ------------------------------------------------------------
	wire cmp_set = match & count_tick;
	wire ovf_set = overflow & count_tick;
	wire cmp_clr = compare_flag_write_one | compare_irq_serviced;
	wire ovf_clr = overflow_flag_write_one | overflow_irq_serviced;

	always_ff @(posedge mclk) begin
		if (rst || !channel_enable_bit) begin
			compare_flag  <= timer_pkg::FLAG_RESET;
			overflow_flag <= timer_pkg::FLAG_RESET;
			compare_irq   <= 1'b0;
			overflow_irq  <= 1'b0;
		end else begin
			compare_flag  <= cmp_set | (compare_flag & ~cmp_clr);
			overflow_flag <= ovf_set | (overflow_flag & ~ovf_clr);
			compare_irq   <= (cmp_set | (compare_flag & ~cmp_clr)) & compare_irq_enable;
			overflow_irq  <= (ovf_set | (overflow_flag & ~ovf_clr)) & overflow_irq_enable;
		end
	end

	// ------------------------------------------------------------
	// Pin output
	// ------------------------------------------------------------
	always_comb begin
		next_pin_drive = pin_drive;
		if (!running || state == ST_IDLE) begin
			next_pin_drive = polarity_invert;
		end else if (count_tick && mode_toggle && match) begin
			next_pin_drive = ~pin_drive;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst || !running || !mode_pulse) begin
			pulse_active <= 1'b0;
		end else if (count_tick) begin
			pulse_active <= match;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			pin_drive <= 1'b0;
		end else begin
			pin_drive <= next_pin_drive;
		end
	end

	wire pin_val_pulse = polarity_invert ^ pulse_active;
	wire pin_val_next  = mode_pulse ? pin_val_pulse : pin_drive;
	// mode 0 leaves pin to GPIO
	wire gpio_oe       = mode_gpio & gpio_drive;
	wire gpio_val      = gpio_out ^ polarity_invert;

	always_ff @(posedge mclk) begin
		if (rst) begin
			timer_pin_out  <= 1'b0;
			timer_pin_oe_n <= timer_pkg::PIN_OE_RESET;
		end else begin
			timer_pin_out  <= pin_is_out ? pin_val_next : gpio_val;
			timer_pin_oe_n <= ~(pin_is_out | gpio_oe);
		end
	end

	// count copy, read never disturbs counter
	always_ff @(posedge mclk) begin
		if (rst) begin
			count_value_reg <= timer_pkg::COUNT_RESET;
		end else begin
			count_value_reg <= next_count;
		end
	end
endmodule

// file: logic/timer_pkg.sv
// Shared constants for one timer channel in its counting modes.
// Assumes a single core clock; no register bus, all fields are ports.
package timer_pkg;
	localparam int          COUNT_WIDTH   = 24;
	localparam int          MODE_WIDTH    = 4;
	localparam logic [3:0]  MODE_GPIO     = 4'h0;
	localparam logic [3:0]  MODE_PULSE    = 4'h1;
	localparam logic [3:0]  MODE_TOGGLE   = 4'h2;
	localparam logic [3:0]  MODE_EVENT    = 4'h3;
	localparam logic [3:0]  MODE_MEAS_LO  = 4'h4;
	localparam logic [3:0]  MODE_MEAS_HI  = 4'h6;
	localparam logic [3:0]  MODE_PWM      = 4'h7;
	localparam logic [3:0]  MODE_WDT_PLS  = 4'h9;
	localparam logic [3:0]  MODE_WDT_TGL  = 4'hA;
	localparam logic [23:0] COUNT_RESET   = 24'h000000;
	localparam logic        FLAG_RESET    = 1'b0;
	localparam logic        PIN_OE_RESET  = 1'b1;
	localparam int          CORE_DIV      = 2;
	localparam int          SYNC_STAGES   = 2;
endpackage

// file: logic/pin_edge_sync.sv
// Pin synchroniser with rising/falling edge pulses.
// Assumes the pin toggles slower than a quarter of mclk.
`timescale 1ns/100ps
module pin_edge_sync (
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Pin side
	input  wire logic pin_in,
	// Outputs
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta;
	logic sync;
	logic prev;

	always_ff @(posedge mclk) begin
		if (rst) begin
			meta <= 1'b0;
			sync <= 1'b0;
			prev <= 1'b0;
		end else begin
			meta <= pin_in;
			sync <= meta;
			prev <= sync;
		end
	end

	assign level = sync;
	assign rise  = sync & ~prev;
	assign fall  = ~sync & prev;
endmodule

// file: bench/timer_chk_assertions.sv
// Port checker for timer_channel.
// Assumes mclk/2 ticks unless the prescaler is selected.
`timescale 1ns/100ps
module timer_chk #(parameter int CW = 24) (
	input wire logic          mclk, rst, channel_enable_bit, reload_on_match,
	input wire logic          polarity_invert, prescaler_select, compare_irq_enable,
	input wire logic [3:0]    mode_select_field,
	input wire logic [CW-1:0] load_value_reg, compare_value_reg, count_value_reg,
	input wire logic          timer_pin_out, timer_pin_oe_n, compare_flag,
	input wire logic          overflow_flag, compare_irq
);
	// Enable history masks the clear that follows enabling
	logic [2:0]    en_h;
	wire           run = channel_enable_bit & en_h[2];
	wire           act = timer_pin_out ^ polarity_invert;
	wire [3:0]     md  = mode_select_field;
	wire [CW-1:0]  c   = count_value_reg;
	wire           top = &count_value_reg;
	always_ff @(posedge mclk) en_h <= rst ? 3'h0 : {en_h[1:0], channel_enable_bit};
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	property p_irq; $rose(compare_flag) && $stable(compare_irq_enable) && compare_irq_enable
		|-> compare_irq; endproperty
	a_irq: assert property (p_irq) else $error("compare irq missing");
	property p_match; $changed(c) && run && $past(c) == $past(compare_value_reg)
		|-> compare_flag; endproperty
	a_match: assert property (p_match) else $error("match without flag");
	property p_step; $changed(c) && run |-> c == CW'($past(c) + 1) || c == load_value_reg;
	endproperty
	a_step: assert property (p_step) else $error("bad count step");
	property p_wrap; $changed(c) && run && $past(top) && $past(c) != $past(compare_value_reg)
		|-> c == 0 && overflow_flag; endproperty
	a_wrap: assert property (p_wrap) else $error("bad overflow");
	property p_clear; $rose(channel_enable_bit) |-> ##[1:2] c == 0; endproperty
	a_clear: assert property (p_clear) else $error("no clear on enable");
	property p_pulse; md == timer_pkg::MODE_PULSE && !prescaler_select && run && $rose(act)
		|=> act ##1 !act; endproperty
	a_pulse: assert property (p_pulse) else $error("pulse width");
	property p_dir; run && md inside {[4'h1:4'h3]}
		|-> timer_pin_oe_n == (md == timer_pkg::MODE_EVENT); endproperty
	a_dir: assert property (p_dir) else $error("pin direction");
	property p_tgl; md == timer_pkg::MODE_TOGGLE && run && $changed(timer_pin_out)
		|-> compare_flag; endproperty
	a_tgl: assert property (p_tgl) else $error("toggle without flag");
endmodule
bind timer_channel timer_chk #(.CW(CW)) i_timer_chk (.*);

// file: bench/pin_source.sv
// Outside signal on the timer pin for event counting.
// Assumes the bench lets it reach the pin only when undriven.
`timescale 1ns/100ps
module pin_source (
	input  wire logic mclk,
	output logic      ext_level
);
	initial ext_level = 1'h1;
	task automatic burst(input int n);
		repeat (n) begin
			repeat (5) @(negedge mclk);
			ext_level = 1'h0;
			repeat (5) @(negedge mclk);
			ext_level = 1'h1;
		end
	endtask
endmodule

// file: bench/timer_channel_tb.sv
// Bench for timer_channel, modes 0 to 3 and idle codes.
// Assumes pin_source on the pin and the bound checker.
`timescale 1ns/100ps
module timer_channel_tb;
	logic        mclk = 0, rst = 1, channel_enable_bit = 0, reload_on_match = 0;
	logic        polarity_invert = 0, prescaler_select = 0, prescaler_tick = 0;
	logic        compare_irq_enable = 1, overflow_irq_enable = 1, gpio_out = 0, gpio_drive = 0;
	logic        compare_flag_write_one = 0, compare_irq_serviced = 0;
	logic        overflow_flag_write_one = 0, overflow_irq_serviced = 0;
	logic [3:0]  mode_select_field = 4'h0;
	logic [23:0] load_value_reg = 24'h0, compare_value_reg = 24'h0, count_value_reg;
	logic        ext_level, timer_pin_out, timer_pin_oe_n, compare_flag, overflow_flag;
	logic        compare_irq, overflow_irq;
	wire         timer_pin_in = timer_pin_oe_n ? ext_level : timer_pin_out;
	int          num_errors = 0, checked = 0, n, pc = 0;
	timer_channel #(.CW(24)) i_timer_channel (.*);
	pin_source i_pin_source (.*);
	initial forever #4 mclk = ~mclk;
	always @(negedge mclk) begin
		pc = (pc + 1) % 5;
		prescaler_tick = pc == 0;
	end
	initial begin
		#20000;
		num_errors++;
		close_out;
	end
	task automatic close_out;
		$display("checked %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic ck(input string s, input logic [23:0] got, exp);
		checked++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", s, exp, got);
		end
	endtask
	task automatic wt(ref logic s, input logic v);
		repeat (300) if (s !== v) @(negedge mclk);
	endtask
	task automatic pulse(ref logic s);
		s = 1'h1;
		@(negedge mclk);
		s = 1'h0;
	endtask
	task automatic start(input logic [3:0] m, input logic [23:0] l, c, input logic [2:0] f);
		channel_enable_bit = 1'h0;
		repeat (2) @(negedge mclk);
		{mode_select_field, load_value_reg, compare_value_reg} = {m, l, c};
		{reload_on_match, polarity_invert, prescaler_select} = f;
		@(negedge mclk);
		channel_enable_bit = 1'h1;
	endtask
	task automatic t_cmp;
		start(4'h0, 24'h5, 24'h8, 3'h4);
		wt(compare_flag, 1'h1);
		ck("gpio dir", timer_pin_oe_n, 24'h1);
		ck("irq", compare_irq, 24'h1);
		ck("reload", count_value_reg, 24'h5);
		gpio_drive = 1'h1;
		gpio_out = 1'h1;
		@(negedge mclk);
		ck("gpio out", {timer_pin_oe_n, timer_pin_out}, 24'h1);
		gpio_drive = 1'h0;
		pulse(compare_irq_serviced);
		ck("serviced", compare_flag, 24'h0);
	endtask
	task automatic t_ovf;
		start(4'h0, 24'hFFFFFD, 24'h10, 3'h1);
		wt(overflow_flag, 1'h1);
		ck("wrap", count_value_reg, 24'h0);
		ck("ovf irq", overflow_irq, 24'h1);
		pulse(overflow_flag_write_one);
		ck("ovf clr", overflow_flag, 24'h0);
	endtask
	task automatic t_pulse;
		start(4'h1, 24'h0, 24'h3, 3'h6);
		repeat (2) @(negedge mclk);
		ck("armed", {timer_pin_oe_n, timer_pin_out}, 24'h1);
		wt(timer_pin_out, 1'h0);
		n = 0;
		repeat (9) if (timer_pin_out === 1'h0) begin
			n++;
			@(negedge mclk);
		end
		ck("width", 24'(n), 24'h2);
		n = 0;
		repeat (20) if (timer_pin_out === 1'h1) begin
			n++;
			@(negedge mclk);
		end
		ck("pulse gap", 24'(n), 24'h6);
	endtask
	task automatic t_tgl;
		start(4'h2, 24'h0, 24'h2, 3'h7);
		wt(timer_pin_out, 1'h0);
		ck("toggle flag", compare_flag, 24'h1);
		repeat (4) @(negedge mclk);
		ck("toggle hold", timer_pin_out, 24'h0);
	endtask
	task automatic t_event;
		compare_irq_enable = 1'h0;
		start(4'h3, 24'h0, 24'h2, 3'h2);
		i_pin_source.burst(3);
		ck("pin in", timer_pin_oe_n, 24'h1);
		ck("events", count_value_reg, 24'h2);
		i_pin_source.burst(1);
		ck("flag no irq", {compare_flag, compare_irq}, 24'h2);
		pulse(compare_flag_write_one);
		ck("cmp clr", compare_flag, 24'h0);
		compare_irq_enable = 1'h1;
	endtask
	task automatic t_idle;
		for (int m = 4; m < 11; m++) begin
			start(4'(m), 24'h0, 24'h0, 3'h0);
			repeat (12) @(negedge mclk);
			ck("idle mode", compare_flag, 24'h0);
			ck("idle clear", count_value_reg, 24'h0);
		end
	endtask
	initial begin
		repeat (8) @(negedge mclk);
		rst = 1'h0;
		t_cmp;
		t_ovf;
		t_pulse;
		t_tgl;
		t_event;
		t_idle;
		close_out;
	end
endmodule
